// ==== ssfr_ctrl_model.sv ====
// Controller model that issues the command strobes of the status block.
`timescale 1ns/10ps
`default_nettype none
module ssfr_ctrl_model (
  // Clock.
  input wire logic clk,
  // Command strobes and named mask bits.
  output logic [9:0] cmd_vec,
  output ssfr_pkg::ssfr_cond_t names
);
  import ssfr_pkg::*;

  // Strobes start idle; the names show a neutral pattern.
  initial begin
    cmd_vec = 10'h000;
    names = 9'h155;
  end

  // Raises one strobe for one cycle just after an edge, names standing with it.
  task automatic send(input int idx, input ssfr_cond_t m);
    @(posedge clk);
    #5;
    cmd_vec = 10'h001 << idx;
    names = m;
    @(posedge clk);
    #5;
    cmd_vec = 10'h000;
    names = ~m; // Released names no longer show the sent value.
  endtask : send
endmodule : ssfr_ctrl_model
`default_nettype wire

// ==== ssfr_defs.svh ====
// Constants for the supply status and fault reporting block.
// Summary of operation
// RULE1: Nine condition bits, voltage bit 0, inhibit 8.
// RULE2: Accumulated bits latch any condition seen since read.
// RULE3: Accumulated query reports the accumulated register.
// RULE4: After that report, reload accumulated from live.
// RULE5: Mask bit lets its condition set fault bit.
// RULE6: Fault bit sets on masked rising condition edge.
// RULE7: Enable mask command sets exactly named bits.
// RULE8: Fault query reports fault register, then clears it.
// RULE9: Overrange fault waits for the recognition delay.
// RULE10: Poll byte layout: summary, power, ready, error, service.
// RULE11: Error bit sets on error, clears on query.
// RULE12: Fault summary is OR of fault bits.
// RULE13: Fault query clears summary only without inhibit.
// RULE14: Ready bit low while commands are processed.
// RULE15: Power-on bit set at power, cleared by clear.
// RULE16: Service bit set on request, cleared by poll.
// RULE17: Request service when summary rises with requests on.
// RULE18: Present query reports live condition register.
// RULE19: Fault bit holds until a fault query clears it.
`ifndef SSFR_DEFS_SVH
`define SSFR_DEFS_SVH

// Condition bit positions, shared by every status-type register.
`define SSFR_BIT_CV 0
`define SSFR_BIT_CC 1
`define SSFR_BIT_OR 2
`define SSFR_BIT_OV 3
`define SSFR_BIT_OT 4
`define SSFR_BIT_AC 5
`define SSFR_BIT_FOLDBACK_TRIP 6
`define SSFR_BIT_ERR 7
`define SSFR_BIT_RI 8
`define SSFR_COND_W 9

// Serial poll byte bit positions.
`define SSFR_POLL_FAU 0
`define SSFR_POLL_PON 1
`define SSFR_POLL_RDY 4
`define SSFR_POLL_ERR 5
`define SSFR_POLL_RQS 6
`define SSFR_POLL_W 8

// Reset values.
`define SSFR_COND_RST 9'h000
`define SSFR_POLL_RST 8'h02

// Width of the overrange recognition delay count, in bits.
`define SSFR_OR_DLY_W 16

`endif

// ==== ssfr_pkg.sv ====
// Types shared by the supply status and fault reporting block.
`default_nettype none
`include "ssfr_defs.svh"
package ssfr_pkg;

  // One status-type register: nine condition bits.
  typedef logic [`SSFR_COND_W-1:0] ssfr_cond_t;

  // The serial poll status byte.
  typedef logic [`SSFR_POLL_W-1:0] ssfr_poll_t;

  // Which register a query answers with.
  typedef enum logic [1:0] {
    SSFR_RPT_NONE = 2'h0,
    SSFR_RPT_PRESENT = 2'h1,
    SSFR_RPT_ACCUM = 2'h2,
    SSFR_RPT_FAULT = 2'h3
  } ssfr_rpt_e;

endpackage : ssfr_pkg
`default_nettype wire

// ==== ssfr_qual.sv ====
// Recognition delay qualifier for a single condition level.
`timescale 1ns/10ps
`default_nettype none
module ssfr_qual #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Condition in, qualified condition out.
  ssfr_qual_if.dst q
);

  // ****************************************
  // Parameter check
  // ****************************************
  generate
    if (W < 1 || W > 16) begin : g_bad_w
      $error("ssfr_qual: W must be 1 to 16");
    end
  endgenerate

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic qual_reg;
  logic qual_next;
  wire logic reached;

  // The condition must stay true for delay plus one cycles to count.
  assign reached = (cnt_reg == q.delay);
  assign cnt_next = !q.cond ? {W{1'b0}} : (reached ? cnt_reg : cnt_reg + W'(1));
  assign qual_next = q.cond && reached; // see RULE9
  assign q.qual = qual_reg;

  // Counter and qualified output; a drop of the condition restarts it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= {W{1'b0}};
      qual_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      qual_reg <= qual_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  short_excursion_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE9
    (q.cond && cnt_reg < q.delay) |=> !q.qual)
    else $error("qualifier passed a short excursion");
  cond_drop_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE9
    !q.cond |=> !q.qual && cnt_reg == {W{1'b0}})
    else $error("qualifier did not restart on drop");

endmodule : ssfr_qual
`default_nettype wire

// ==== ssfr_qual_if.sv ====
// Interface between the status logic and the overrange qualifier.
`timescale 1ns/10ps
`default_nettype none
interface ssfr_qual_if #(parameter int W = 16) ();
  logic cond;
  logic [W-1:0] delay;
  logic qual;
  modport src (output cond, output delay, input qual);
  modport dst (input cond, input delay, output qual);
endinterface : ssfr_qual_if
`default_nettype wire

// ==== ssfr_top.sv ====
// Status registers, fault latching and serial poll byte of the supply.
`timescale 1ns/10ps
`default_nettype none
`include "ssfr_defs.svh"
module ssfr_top #(
  parameter int OR_DLY_W = `SSFR_OR_DLY_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Live conditions and device state.
  input wire ssfr_pkg::ssfr_cond_t cond_live,
  input wire logic remote_inhibit_input,
  input wire logic [OR_DLY_W-1:0] or_delay,
  input wire logic prog_error_evt,
  input wire logic cmd_busy,
  // Decoded command strobes, one cycle each.
  input wire logic present_query_cmd,
  input wire logic accum_query_cmd,
  input wire logic fault_query_cmd,
  input wire logic error_query_cmd,
  input wire logic enable_mask_cmd,
  input wire ssfr_pkg::ssfr_cond_t mask_names,
  input wire logic clear_cmd,
  input wire logic dev_clear_msg,
  input wire logic srq_on_cmd,
  input wire logic srq_off_cmd,
  input wire logic serial_poll_done,
  // Query answer.
  output logic report_valid,
  output ssfr_pkg::ssfr_cond_t report_data,
  // Serial poll byte and service request line.
  output ssfr_pkg::ssfr_poll_t poll_byte,
  output logic srq_out
);
  import ssfr_pkg::*;

  // ****************************************
  // Parameter check
  // ****************************************
  generate
    if (OR_DLY_W < 1 || OR_DLY_W > 16) begin : g_bad_w
      $error("ssfr_top: OR_DLY_W must be 1 to 16");
    end
  endgenerate

  // ****************************************
  // Storage
  // ****************************************
  ssfr_cond_t accum_reg;
  ssfr_cond_t accum_next;
  ssfr_cond_t mask_reg;
  ssfr_cond_t mask_next;
  ssfr_cond_t fault_reg;
  ssfr_cond_t fault_next;
  ssfr_cond_t prev_reg;
  ssfr_cond_t cond_eff;
  ssfr_cond_t rise;
  ssfr_cond_t report_next;
  logic fau_keep_reg;
  logic fau_keep_next;
  logic fau_reg;
  logic fau_next;
  logic err_reg;
  logic err_next;
  logic pon_reg;
  logic pon_next;
  logic rqs_reg;
  logic rqs_next;
  logic srq_en_reg;
  logic srq_en_next;
  ssfr_poll_t poll_next;
  ssfr_rpt_e rpt_sel;
  wire logic do_present;
  wire logic do_accum;
  wire logic do_fault;
  wire logic srq_raise;

  // ****************************************
  // Overrange recognition delay
  // ****************************************
  ssfr_qual_if #(.W(OR_DLY_W)) qual_bus ();

  // Only the overrange condition passes through the delay.
  assign qual_bus.cond = cond_live[`SSFR_BIT_OR];
  assign qual_bus.delay = or_delay;

  ssfr_qual #(.W(OR_DLY_W)) u_or_qual (
    .clk(clk),
    .rst_n(rst_n),
    .q(qual_bus)
  );

  // ****************************************
  // Query decode
  // ****************************************
  // Should two queries come together, the fault query wins, then the
  // accumulated one; the losing query has no effect at all.
  assign rpt_sel = fault_query_cmd ? SSFR_RPT_FAULT :
                   accum_query_cmd ? SSFR_RPT_ACCUM :
                   present_query_cmd ? SSFR_RPT_PRESENT : SSFR_RPT_NONE;
  assign do_present = (rpt_sel == SSFR_RPT_PRESENT);
  assign do_accum = (rpt_sel == SSFR_RPT_ACCUM);
  assign do_fault = (rpt_sel == SSFR_RPT_FAULT);

  // Answer value chosen by the query; each weight is a power of two.
  always_comb begin
    case (rpt_sel)
      SSFR_RPT_PRESENT: report_next = cond_live; // see RULE18
      SSFR_RPT_ACCUM: report_next = accum_reg; // see RULE3
      SSFR_RPT_FAULT: report_next = fault_reg; // see RULE8
      default: report_next = `SSFR_COND_RST;
    endcase
  end

  // ****************************************
  // Condition registers
  // ****************************************
  // Conditions as seen by the fault logic: overrange is the delayed copy.
  always_comb begin
    cond_eff = cond_live; // see RULE1
    cond_eff[`SSFR_BIT_OR] = qual_bus.qual; // see RULE9
  end

  // Accumulated bits latch; a read reloads them from the live bits, so a
  // condition true in the read cycle is kept rather than lost.
  assign accum_next = do_accum ? cond_live : (accum_reg | cond_live); // see RULE2 see RULE4

  // The mask command replaces the whole mask with the named bits.
  assign mask_next = enable_mask_cmd ? mask_names : mask_reg; // see RULE7

  // Masked rising edges; an edge in the clearing cycle still sets.
  assign rise = cond_eff & ~prev_reg & mask_reg; // see RULE5 see RULE6
  assign fault_next = (do_fault ? `SSFR_COND_RST : fault_reg) | rise; // see RULE8 see RULE19

  // ****************************************
  // Poll byte flags
  // ****************************************
  // With the inhibit line active a fault query leaves the summary set,
  // until a later fault query finds the line inactive.
  assign fau_keep_next = do_fault ? (remote_inhibit_input & fau_reg) : fau_keep_reg; // see RULE13
  assign fau_next = (|fault_next) | fau_keep_next; // see RULE12

  // Error flag: a new error in the query cycle wins over the clear.
  assign err_next = prog_error_evt | (err_reg & ~error_query_cmd); // see RULE11

  // Power-on flag falls on clear or on the bus device clear.
  assign pon_next = pon_reg & ~(clear_cmd | dev_clear_msg); // see RULE15

  // Service request enable; on wins if both arrive together.
  assign srq_en_next = srq_on_cmd | (srq_en_reg & ~srq_off_cmd);

  // A rising summary with requests enabled asks for service; a request
  // in the poll cycle is kept.
  assign srq_raise = fau_next & ~fau_reg & srq_en_reg; // see RULE17
  assign rqs_next = srq_raise | (rqs_reg & ~serial_poll_done); // see RULE16

  // Poll byte assembly; unused bits read zero.
  always_comb begin
    poll_next = 8'h00; // see RULE10
    poll_next[`SSFR_POLL_FAU] = fau_next;
    poll_next[`SSFR_POLL_PON] = pon_next;
    poll_next[`SSFR_POLL_RDY] = ~cmd_busy; // see RULE14
    poll_next[`SSFR_POLL_ERR] = err_next;
    poll_next[`SSFR_POLL_RQS] = rqs_next;
  end

  // ****************************************
  // Registers
  // ****************************************
  // Status storage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      accum_reg <= `SSFR_COND_RST;
      mask_reg <= `SSFR_COND_RST;
      fault_reg <= `SSFR_COND_RST;
      prev_reg <= `SSFR_COND_RST;
    end else begin
      accum_reg <= accum_next;
      mask_reg <= mask_next;
      fault_reg <= fault_next;
      prev_reg <= cond_eff;
    end
  end

  // Flag storage; power-on starts set.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fau_keep_reg <= 1'b0;
      fau_reg <= 1'b0;
      err_reg <= 1'b0;
      pon_reg <= 1'b1;
      rqs_reg <= 1'b0;
      srq_en_reg <= 1'b0;
    end else begin
      fau_keep_reg <= fau_keep_next;
      fau_reg <= fau_next;
      err_reg <= err_next;
      pon_reg <= pon_next;
      rqs_reg <= rqs_next;
      srq_en_reg <= srq_en_next;
    end
  end

  // Output flip-flops.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      report_valid <= 1'b0;
      report_data <= `SSFR_COND_RST;
      poll_byte <= `SSFR_POLL_RST;
      srq_out <= 1'b0;
    end else begin
      report_valid <= do_present | do_accum | do_fault;
      report_data <= report_next;
      poll_byte <= poll_next;
      srq_out <= rqs_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Steps of a service request.
  sequence fau_up_s;
    srq_en_reg && fau_next && !fau_reg;
  endsequence
  sequence rqs_shown_s;
    srq_out && poll_byte[`SSFR_POLL_RQS] && poll_byte[`SSFR_POLL_FAU];
  endsequence

  // Steps of a fault query.
  sequence fault_ask_s;
    fault_query_cmd;
  endsequence
  sequence fault_told_s;
    report_valid && report_data == $past(fault_reg) && fault_reg == $past(rise);
  endsequence

  srq_raise_a: assert property (fau_up_s |=> rqs_shown_s) // see RULE17
    else $error("service request not raised");
  fault_query_a: assert property (fault_ask_s |=> fault_told_s) // see RULE8
    else $error("fault query answer or clear wrong");
  accum_reload_a: assert property ( // see RULE4
    (accum_query_cmd && !fault_query_cmd) |=>
      report_data == $past(accum_reg) && accum_reg == $past(cond_live))
    else $error("accumulated read or reload wrong");
  accum_latch_a: assert property ( // see RULE2
    !(accum_query_cmd && !fault_query_cmd) |=>
      (accum_reg & $past(cond_live)) == $past(cond_live) &&
      (accum_reg & $past(accum_reg)) == $past(accum_reg))
    else $error("accumulated bit lost");
  present_query_a: assert property ( // see RULE18
    (present_query_cmd && !accum_query_cmd && !fault_query_cmd) |=>
      report_valid && report_data == $past(cond_live))
    else $error("present status answer wrong");
  fault_hold_a: assert property ( // see RULE19
    !fault_query_cmd |=> (fault_reg & $past(fault_reg)) == $past(fault_reg))
    else $error("fault bit dropped without query");
  fault_cause_a: assert property ( // see RULE6
    ((fault_reg & ~$past(fault_reg)) & ~($past(mask_reg) & $past(cond_eff) &
      ~$past(prev_reg))) == `SSFR_COND_RST)
    else $error("fault bit set without masked edge");
  mask_load_a: assert property ( // see RULE7
    enable_mask_cmd |=> mask_reg == $past(mask_names) ##1 $stable(mask_reg) || $past(enable_mask_cmd))
    else $error("mask not loaded with named bits");
  fau_summary_a: assert property ( // see RULE12
    poll_byte[`SSFR_POLL_FAU] == ((|fault_reg) | fau_keep_reg))
    else $error("fault summary not OR of faults");
  inhibit_keep_a: assert property ( // see RULE13
    (fault_query_cmd && remote_inhibit_input && poll_byte[`SSFR_POLL_FAU]) |=>
      poll_byte[`SSFR_POLL_FAU])
    else $error("summary cleared under inhibit");
  err_flag_a: assert property ( // see RULE11
    (error_query_cmd && !prog_error_evt) |=> !poll_byte[`SSFR_POLL_ERR] ##1
      (poll_byte[`SSFR_POLL_ERR] == $past(prog_error_evt)))
    else $error("error flag wrong");
  pon_clear_a: assert property ( // see RULE15
    (clear_cmd || dev_clear_msg) |=> !poll_byte[`SSFR_POLL_PON] [*2])
    else $error("power-on flag not cleared");
  // The first edge after reset still shows the reset byte, so it is skipped.
  ready_flag_a: assert property ( // see RULE14
    $past(rst_n) |-> poll_byte[`SSFR_POLL_RDY] == !$past(cmd_busy))
    else $error("ready flag wrong");
  poll_clear_a: assert property ( // see RULE16
    (serial_poll_done && !srq_raise) |=> !poll_byte[`SSFR_POLL_RQS] && !srq_out)
    else $error("service bit not cleared by poll");
  unused_bits_a: assert property ( // see RULE10
    poll_byte[7] == 1'b0 && poll_byte[3:2] == 2'h0)
    else $error("unused poll bits not zero");

endmodule : ssfr_top
`default_nettype wire

// ==== test_supply_status_fault_reporting.sv ====
// Self-checking testbench of the supply status and fault reporting block.
`timescale 1ns/10ps
`default_nettype none
module test_supply_status_fault_reporting;
  import ssfr_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int PQ = 0, AQ = 1, FQ = 2, EQ = 3, MK = 4;
  localparam int CL = 5, DC = 6, SON = 7, SOFF = 8, PD = 9;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ssfr_cond_t cond_live = 9'h000;
  logic remote_inhibit_input = 1'b0;
  logic [15:0] or_delay = 16'h0003;
  logic prog_error_evt = 1'b0;
  logic cmd_busy = 1'b0;
  logic [9:0] cmd_vec;
  ssfr_cond_t names;
  logic report_valid;
  ssfr_cond_t report_data;
  ssfr_poll_t poll_byte;
  logic srq_out;
  int err_total = 0;
  int checked = 0;

  ssfr_ctrl_model ssfr_ctrl_model_i (.clk(clk), .cmd_vec(cmd_vec), .names(names));

  ssfr_top ssfr_top_i (
    .clk(clk), .rst_n(rst_n), .cond_live(cond_live),
    .remote_inhibit_input(remote_inhibit_input), .or_delay(or_delay),
    .prog_error_evt(prog_error_evt), .cmd_busy(cmd_busy),
    .present_query_cmd(cmd_vec[PQ]), .accum_query_cmd(cmd_vec[AQ]),
    .fault_query_cmd(cmd_vec[FQ]), .error_query_cmd(cmd_vec[EQ]),
    .enable_mask_cmd(cmd_vec[MK]), .mask_names(names), .clear_cmd(cmd_vec[CL]),
    .dev_clear_msg(cmd_vec[DC]), .srq_on_cmd(cmd_vec[SON]),
    .srq_off_cmd(cmd_vec[SOFF]), .serial_poll_done(cmd_vec[PD]),
    .report_valid(report_valid), .report_data(report_data),
    .poll_byte(poll_byte), .srq_out(srq_out)
  );

  // Clock of 50 ns period.
  always #25 clk = ~clk;

  // ****************************************
  // Tasks
  // ****************************************
  // Waits n edges and lands just after the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : tick

  // Sends a query and checks the one-cycle answer.
  task automatic chk_rpt(input int idx, input ssfr_cond_t exp);
    ssfr_ctrl_model_i.send(idx, 9'h000);
    checked++;
    if (report_valid !== 1'b1 || report_data !== exp) begin
      err_total++;
      $display("Error at %0t: report %h, expected %h", $time, report_data, exp);
    end
  endtask : chk_rpt

  // Compares the selected bits of the poll byte.
  task automatic chk_byte(input ssfr_poll_t m, input ssfr_poll_t exp);
    checked++;
    if ((poll_byte & m) !== (exp & m)) begin
      err_total++;
      $display("Error at %0t: poll byte %h, expected %h", $time, poll_byte, exp);
    end
  endtask : chk_byte

  // Compares the service request line.
  task automatic chk_line(input logic exp);
    checked++;
    if (srq_out !== exp) begin
      err_total++;
      $display("Error at %0t: request line %b, expected %b", $time, srq_out, exp);
    end
  endtask : chk_line

  // Prints the verdict and ends the run.
  task automatic test_done();
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // ****************************************
  // Tests
  // ****************************************
  // Main sequence of command calls with expected values.
  initial begin
    repeat (6) @(posedge clk);
    #5;
    rst_n = 1'b1;
    tick(1);
    chk_byte(8'hFF, 8'h12);
    cmd_busy = 1'b1;
    tick(1);
    chk_byte(8'h10, 8'h00);
    cmd_busy = 1'b0;
    cond_live = 9'h001;
    chk_rpt(AQ, 9'h001);
    cond_live = 9'h009;
    tick(1);
    cond_live = 9'h001;
    chk_rpt(AQ, 9'h009);
    chk_rpt(AQ, 9'h001);
    cond_live = 9'h181;
    chk_rpt(PQ, 9'h181);
    cond_live = 9'h000;
    ssfr_ctrl_model_i.send(MK, 9'h1FF);
    ssfr_ctrl_model_i.send(MK, 9'h008);
    cond_live = 9'h00A;
    tick(1);
    chk_byte(8'h01, 8'h01);
    cond_live = 9'h000;
    ssfr_ctrl_model_i.send(MK, 9'h000);
    chk_rpt(FQ, 9'h008);
    chk_byte(8'h01, 8'h00);
    chk_rpt(FQ, 9'h000);
    ssfr_ctrl_model_i.send(MK, 9'h008);
    remote_inhibit_input = 1'b1;
    cond_live = 9'h008;
    chk_rpt(FQ, 9'h008);
    chk_byte(8'h01, 8'h01);
    remote_inhibit_input = 1'b0;
    cond_live = 9'h000;
    chk_rpt(FQ, 9'h000);
    chk_byte(8'h01, 8'h00);
    ssfr_ctrl_model_i.send(SON, 9'h000);
    cond_live = 9'h008;
    tick(1);
    chk_byte(8'h41, 8'h41);
    chk_line(1'b1);
    ssfr_ctrl_model_i.send(PD, 9'h000);
    chk_byte(8'h41, 8'h01);
    chk_line(1'b0);
    ssfr_ctrl_model_i.send(SOFF, 9'h000);
    cond_live = 9'h000;
    chk_rpt(FQ, 9'h008);
    ssfr_ctrl_model_i.send(MK, 9'h004);
    cond_live = 9'h004;
    tick(3);
    cond_live = 9'h000;
    tick(3);
    chk_rpt(FQ, 9'h000);
    cond_live = 9'h004;
    tick(5);
    cond_live = 9'h000;
    tick(3);
    chk_byte(8'h41, 8'h01);
    chk_line(1'b0);
    chk_rpt(FQ, 9'h004);
    prog_error_evt = 1'b1;
    tick(1);
    prog_error_evt = 1'b0;
    chk_byte(8'h20, 8'h20);
    ssfr_ctrl_model_i.send(EQ, 9'h000);
    chk_byte(8'h20, 8'h00);
    ssfr_ctrl_model_i.send(CL, 9'h000);
    chk_byte(8'h02, 8'h00);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(1);
    chk_byte(8'h02, 8'h02);
    ssfr_ctrl_model_i.send(DC, 9'h000);
    chk_byte(8'h02, 8'h00);
    test_done();
  end

  // Watchdog that cuts a hung run short.
  initial begin
    #200000;
    err_total++;
    test_done();
  end
endmodule : test_supply_status_fault_reporting
`default_nettype wire
